// ---- design/tsaoc_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants of the two-step converter output control
// ----------------------------------------------------------------------------
package tsaoc_pkg;

   // Code and level widths
   localparam int CODE_W   = 10;
   localparam int LVL_W    = 12;
   localparam int COARSE_W = 5;
   localparam int FINE_W   = 6;
   localparam int SYNC_LEN = 3;

   // Level arithmetic, 13-bit signed, in LSB units above the bottom reference
   localparam logic signed [12:0] LVL_ZERO   = 13'sh0000;
   localparam logic signed [12:0] LVL_TOP    = 13'sh03FF;  // Step 1023
   localparam logic signed [12:0] REDUNDANCY = 13'sh0010;  // 16 LSB either side
   localparam logic signed [12:0] FINE_MAX   = 13'sh003F;  // Fine span 0..63

   // Control pin positions inside the synchronised pin vector
   localparam int PIN_MSB = 0;
   localparam int PIN_LOW = 1;
   localparam int PIN_EN  = 2;
   localparam int PIN_SAVE = 3;
   localparam int PIN_W   = 4;

   // Register byte offsets
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_MASK   = 8'h08;
   localparam logic [7:0] OFF_SAMPLE = 8'h0C;

   // Field positions and reset values
   localparam int CTRL_RUN   = 0;
   localparam int EV_W       = 3;
   localparam int EV_TOP     = 0;
   localparam int EV_BOT     = 1;
   localparam int EV_PSAVE   = 2;
   localparam int SMP_TOP    = 10;
   localparam int SMP_BOT    = 11;
   localparam int SMP_PSAVE  = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [2:0]  MASK_RST = 3'h0;

endpackage : tsaoc_pkg

// ---- design/tsaoc_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tsaoc_top (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Held levels in LSB units above the bottom reference
   input  wire logic signed [11:0]   coarse_stage_input,
   input  wire logic signed [11:0]   fine_stage_input,
   // Control pins
   input  wire logic                 msb_invert_n,
   input  wire logic                 lower_bits_invert_n,
   input  wire logic                 out_enable_n,
   input  wire logic                 power_save_req,
   // Sample outputs with enables
   output logic      [9:0]           sample_code,
   output logic                      sample_code_oe,
   output logic                      top_exceed_flag,
   output logic                      bottom_exceed_flag,
   output logic                      flags_oe,
   output logic                      power_save_active,
   output logic                      irq
);

   // -------------------------------------------------------------------------
   // Reset release and pin synchronisers
   // -------------------------------------------------------------------------
   logic [1:0]                 rst_ff_q;
   logic                       rst_n_s;
   logic [3:0]                 pin_raw;
   logic [3:0]                 pin_lvl;

   // Reset enters asynchronously but is released on the clock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rst_ff_q <= 2'h0;
      else       rst_ff_q <= {rst_ff_q[0], 1'b1};
   end
   assign rst_n_s = rst_ff_q[1];

   assign pin_raw = {power_save_req, out_enable_n, lower_bits_invert_n, msb_invert_n};

   // Three stages per pin; the level moves only once stages two and three agree
   for (genvar g = 0; g < tsaoc_pkg::PIN_W; g++) begin : g_sync
      logic [2:0] sh_q;
      logic       lvl_q;
      always_ff @(posedge clk or negedge rst_n_s) begin
         if (!rst_n_s) sh_q <= 3'h7;
         else          sh_q <= {sh_q[1:0], pin_raw[g]};
      end
      always_ff @(posedge clk or negedge rst_n_s) begin
         if (!rst_n_s)            lvl_q <= 1'b1;
         else if (sh_q[1] == sh_q[2]) lvl_q <= sh_q[2];
      end
      assign pin_lvl[g] = lvl_q;
   end

   logic                       msb_n_s;
   logic                       low_n_s;
   logic                       en_n_s;
   logic                       save_s;
   assign msb_n_s = pin_lvl[tsaoc_pkg::PIN_MSB];
   assign low_n_s = pin_lvl[tsaoc_pkg::PIN_LOW];
   assign en_n_s  = pin_lvl[tsaoc_pkg::PIN_EN];
   assign save_s  = pin_lvl[tsaoc_pkg::PIN_SAVE];

   // -------------------------------------------------------------------------
   // Power save and conversion hold
   // -------------------------------------------------------------------------
   logic                       psave_d;
   logic                       psave_q;
   logic [31:0]                ctrl_q;
   logic                       hold;

   // Both pins high are needed; a lone power save request is ignored
   assign psave_d = save_s & en_n_s;
   assign hold    = psave_q | ~ctrl_q[tsaoc_pkg::CTRL_RUN];

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) psave_q <= 1'b1;
      else          psave_q <= psave_d;
   end

   // -------------------------------------------------------------------------
   // Coarse stage, rising edge
   // -------------------------------------------------------------------------
   logic signed [12:0]         coarse_ext;
   logic [9:0]                 coarse_clamp;
   logic [4:0]                 coarse_idx_q;
   logic [9:0]                 coarse_lvl_q;

   assign coarse_ext   = {coarse_stage_input[11], coarse_stage_input};
   assign coarse_clamp = (coarse_ext < tsaoc_pkg::LVL_ZERO) ? 10'h000 :
                         (coarse_ext > tsaoc_pkg::LVL_TOP)  ? 10'h3FF : coarse_ext[9:0];

   // Upper bank resolves one of 32 steps of 32 LSB; the full level is kept to judge the window
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         coarse_idx_q <= 5'h00;
         coarse_lvl_q <= 10'h000;
      end else if (!hold) begin
         coarse_idx_q <= coarse_clamp[9:5];
         coarse_lvl_q <= coarse_clamp;
      end
   end

   // -------------------------------------------------------------------------
   // Fine stage, falling edge
   // -------------------------------------------------------------------------
   logic signed [12:0]         base;
   logic signed [12:0]         fine_ext;
   logic signed [12:0]         resid;
   logic [5:0]                 resid_clamp;
   logic [9:0]                 fine_clamp;
   logic signed [12:0]         fine_gap;
   logic                       fine_win;
   logic [5:0]                 fine_res_q;
   logic                       fine_over_q;
   logic                       fine_under_q;
   logic [9:0]                 fine_ref_q;
   logic                       win_q;

   // Fine window starts 16 LSB below the coarse step, giving redundancy both ways
   assign base        = $signed({3'h0, coarse_idx_q, 5'h00}) - tsaoc_pkg::REDUNDANCY;
   assign fine_ext    = {fine_stage_input[11], fine_stage_input};
   assign resid       = fine_ext - base;
   assign resid_clamp = (resid < tsaoc_pkg::LVL_ZERO) ? 6'h00 :
                        (resid > tsaoc_pkg::FINE_MAX) ? 6'h3F : resid[5:0];
   assign fine_clamp  = (fine_ext < tsaoc_pkg::LVL_ZERO) ? 10'h000 :
                        (fine_ext > tsaoc_pkg::LVL_TOP)  ? 10'h3FF : fine_ext[9:0];
   assign fine_gap    = fine_ext - $signed({3'h0, coarse_lvl_q});
   // Window is judged against the level the upper bank latched; a moving input cannot fake it
   assign fine_win    = (fine_gap <= tsaoc_pkg::REDUNDANCY) &&
                        (fine_gap >= -tsaoc_pkg::REDUNDANCY);

   // Lower bank latches on the falling edge, after the held level has settled
   always_ff @(negedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         fine_res_q   <= 6'h00;
         fine_over_q  <= 1'b0;
         fine_under_q <= 1'b0;
         fine_ref_q   <= 10'h000;
         win_q        <= 1'b0;
      end else if (!hold) begin
         fine_res_q   <= resid_clamp;
         fine_over_q  <= fine_ext > tsaoc_pkg::LVL_TOP;
         fine_under_q <= fine_ext < tsaoc_pkg::LVL_ZERO;
         fine_ref_q   <= fine_clamp;
         win_q        <= fine_win;
      end
   end

   // -------------------------------------------------------------------------
   // Correction, coding and output registers
   // -------------------------------------------------------------------------
   logic signed [12:0]         corr;
   logic [9:0]                 bin_d;
   logic [9:0]                 code_d;
   logic [9:0]                 bin_q;
   logic [9:0]                 code_q;
   logic                       top_q;
   logic                       bot_q;
   logic                       oe_q;

   assign corr   = base + $signed({7'h00, fine_res_q});
   assign bin_d  = (corr < tsaoc_pkg::LVL_ZERO) ? 10'h000 :
                   (corr > tsaoc_pkg::LVL_TOP)  ? 10'h3FF : corr[9:0];
   // Inversions act only on the code, never on the flags
   assign code_d = {bin_d[9] ^ ~msb_n_s,
                    bin_d[8:0] ^ {9{~low_n_s}}};

   // Code and flags move together on the rising edge; frozen while held
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         bin_q  <= 10'h000;
         code_q <= 10'h000;
         top_q  <= 1'b0;
         bot_q  <= 1'b0;
      end else if (!hold) begin
         bin_q  <= bin_d;
         code_q <= code_d;
         top_q  <= fine_over_q;
         bot_q  <= fine_under_q;
      end
   end

   // Enable path is not held, so power save never traps the drivers on
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) oe_q <= 1'b0;
      else          oe_q <= ~en_n_s;
   end

   assign sample_code        = code_q;
   assign sample_code_oe     = oe_q;
   assign top_exceed_flag    = top_q;
   assign bottom_exceed_flag = bot_q;
   assign flags_oe           = oe_q;
   assign power_save_active  = psave_q;

   // -------------------------------------------------------------------------
   // APB slave, no wait states
   // -------------------------------------------------------------------------
   logic                       setup;
   logic                       acc_wr;
   logic                       hit_ctrl;
   logic                       hit_status;
   logic                       hit_mask;
   logic                       hit_sample;
   logic                       mapped;
   logic [31:0]                rd_mux;
   logic [31:0]                prdata_q;
   logic                       pready_q;
   logic                       pslverr_q;
   logic [2:0]                 status_q;
   logic [2:0]                 status_d;
   logic [2:0]                 mask_q;
   logic [2:0]                 ev_set;
   logic [2:0]                 ev_clr;
   logic                       irq_q;

   assign setup      = psel & ~penable;
   assign acc_wr     = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign hit_ctrl   = paddr == tsaoc_pkg::OFF_CTRL;
   assign hit_status = paddr == tsaoc_pkg::OFF_STATUS;
   assign hit_mask   = paddr == tsaoc_pkg::OFF_MASK;
   assign hit_sample = paddr == tsaoc_pkg::OFF_SAMPLE;
   assign mapped     = hit_ctrl | hit_status | hit_mask | hit_sample;
   assign rd_mux     = hit_ctrl   ? ctrl_q :
                       hit_status ? {29'h0, status_q} :
                       hit_mask   ? {29'h0, mask_q} :
                       hit_sample ? {19'h0, psave_q, bot_q, top_q, bin_q} : 32'h0;

   // Answer lands in the access cycle; unmapped addresses return an error
   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s)              ctrl_q <= tsaoc_pkg::CTRL_RST;
      else if (acc_wr & hit_ctrl) ctrl_q <= pwdata;
   end

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s)              mask_q <= tsaoc_pkg::MASK_RST;
      else if (acc_wr & hit_mask) mask_q <= pwdata[2:0];
   end

   // Sticky events; a new event outranks a same-cycle write-one clear
   assign ev_set[tsaoc_pkg::EV_TOP]   = ~hold & fine_over_q;
   assign ev_set[tsaoc_pkg::EV_BOT]   = ~hold & fine_under_q;
   assign ev_set[tsaoc_pkg::EV_PSAVE] = psave_d & ~psave_q;
   assign ev_clr   = (acc_wr & hit_status) ? pwdata[2:0] : 3'h0;
   assign status_d = (status_q & ~ev_clr) | ev_set;

   always_ff @(posedge clk or negedge rst_n_s) begin
      if (!rst_n_s) begin
         status_q <= 3'h0;
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         irq_q    <= |(status_q & mask_q);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_s);

   a_coarse_latch: assert property (!hold |=>
      {coarse_idx_q, 5'h00} == ($past(coarse_clamp) & 10'h3E0))
      else $error("coarse step not latched");
   a_fine_latch: assert property (@(negedge clk) disable iff (!rst_n_s)
      !hold |=> fine_res_q == $past(resid_clamp))
      else $error("fine residue not latched on falling edge");
   a_exact_window: assert property ((win_q && !hold) |=> bin_q == $past(fine_ref_q))
      else $error("corrected code differs from settled level");
   a_hold_freeze: assert property (hold |=> $stable(code_q) && $stable(top_q))
      else $error("outputs moved while held");
   a_msb_invert: assert property (!hold |=> (code_q[9] ^ bin_q[9]) == !$past(msb_n_s))
      else $error("top code bit inversion wrong");
   a_low_invert: assert property (!hold |=>
      (code_q[8:0] ^ bin_q[8:0]) == (!$past(low_n_s) ? 9'h1FF : 9'h000))
      else $error("lower code bits inversion wrong");
   a_straight_bin: assert property ((!hold && msb_n_s && low_n_s) |=> code_q == bin_q)
      else $error("straight binary code mismatch");
   a_enable_drive: assert property (en_n_s [*2] |=> !sample_code_oe && !flags_oe)
      else $error("outputs driven while enable pin high");
   a_psave_entry: assert property (psave_q == ($past(save_s) && $past(en_n_s)))
      else $error("power save state mismatch");
   a_top_flag: assert property (!hold |=> top_q == $past(fine_over_q))
      else $error("top flag does not follow sample");
   a_bot_flag: assert property (!hold |=> bot_q == $past(fine_under_q))
      else $error("bottom flag does not follow sample");
   a_flag_fixed: assert property ((!hold && $changed(msb_n_s)) |=> top_q == $past(fine_over_q))
      else $error("flag altered by inversion");
   a_reset_release: assert property ($rose(rst_n_s) |-> !oe_q && code_q == 10'h000)
      else $error("outputs not released after reset");

   c_in_window: cover property (win_q && !hold ##1 bin_q == 10'h200);
   c_overflow: cover property (!hold && fine_over_q ##1 top_exceed_flag);
   c_psave: cover property (!psave_q ##1 psave_q ##1 irq);
   c_twos_comp: cover property (!msb_n_s && low_n_s && sample_code_oe);

endmodule : tsaoc_top

`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic               clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd;
   logic signed [11:0] coarse_lvl, fine_lvl;
   logic               msb_inv_n, low_inv_n, oen, save_req;
   logic [9:0]         code, cap_code;
   logic               code_oe, top_f, bot_f, f_oe, save_act, irq, cap_top, cap_bot;
   int                 fail_count, checks_done;

   // Clock at 100 MHz; both phases stay far above any minimum width
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Design and downstream capture
   tsaoc_top u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .coarse_stage_input(coarse_lvl), .fine_stage_input(fine_lvl), .msb_invert_n(msb_inv_n),
      .lower_bits_invert_n(low_inv_n), .out_enable_n(oen), .power_save_req(save_req),
      .sample_code(code), .sample_code_oe(code_oe), .top_exceed_flag(top_f),
      .bottom_exceed_flag(bot_f), .flags_oe(f_oe), .power_save_active(save_act), .irq(irq));
   tsaoc_capture u_cap (.clk(clk), .sample_code(code), .sample_code_oe(code_oe),
      .top_exceed_flag(top_f), .bottom_exceed_flag(bot_f), .flags_oe(f_oe),
      .cap_code(cap_code), .cap_top(cap_top), .cap_bot(cap_bot));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1, "apb answer");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Held levels stay put after this edge, settled before any latch
   task automatic level(input int lv, input int off);
      @(posedge clk);
      coarse_lvl <= 12'(lv + off);
      fine_lvl   <= 12'(lv);
      repeat (6) @(posedge clk);
   endtask : level

   // Control pins pass a filter, so give them time to land
   task automatic pins(input logic m, input logic l, input logic e, input logic p);
      @(posedge clk);
      msb_inv_n <= m;
      low_inv_n <= l;
      oen       <= e;
      save_req  <= p;
      repeat (10) @(posedge clk);
   endtask : pins

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      apb(1'b0, tsaoc_pkg::OFF_CTRL, 32'h0);
      chk(rd, tsaoc_pkg::CTRL_RST, "ctrl reset value");
      apb(1'b0, tsaoc_pkg::OFF_MASK, 32'h0);
      chk(rd, 32'h0, "mask reset value");
      apb(1'b0, 8'h10, 32'h0);
      chk({rd[31:1], err}, 32'h1, "unmapped read");
      chk({30'h0, code_oe, f_oe}, 32'h3, "driven with enable low");
      chk({31'h0, save_act}, 32'h0, "awake with enable low");
      $display("test reset done");
   endtask : t_reset

   // Coarse sits inside the correction window, on both sides and at its edges
   task automatic t_codes();
      int lv[7]  = '{0, 1, 2, 3, 512, 1019, 1023};
      int off[7] = '{16, -1, 5, -3, -16, 4, -16};
      for (int i = 0; i < 7; i++) begin
         level(lv[i], off[i]);
         chk({22'h0, cap_code}, 32'(lv[i]), "binary code");
         chk({22'h0, code}, 32'(lv[i]), "code on pins");
         chk({30'h0, cap_top, cap_bot}, 32'h0, "in range flags");
      end
      $display("test codes done");
   endtask : t_codes

   // All four codings, then out of range with both inversions active
   task automatic t_invert();
      logic [9:0] e;
      level(341, 7);
      for (int i = 3; i >= 0; i--) begin
         pins(i[1], i[0], 1'b0, 1'b0);
         e = 10'h155 ^ {~i[1], {9{~i[0]}}};
         chk({22'h0, cap_code}, {22'h0, e}, "msb coding");
         chk({23'h0, cap_code[8:0]}, {23'h0, e[8:0]}, "lower coding");
      end
      level(1100, 0);
      chk({20'h0, cap_top, cap_bot, cap_code}, 32'h800, "over range");
      level(-5, 0);
      chk({20'h0, cap_top, cap_bot, cap_code}, 32'h7FF, "under range");
      chk({30'h0, top_f, bot_f}, 32'h1, "flags not inverted");
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      apb(1'b0, tsaoc_pkg::OFF_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h3, "range events");
      chk({31'h0, irq}, 32'h0, "masked");
      apb(1'b1, tsaoc_pkg::OFF_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "unmasked");
      level(100, 0);
      apb(1'b1, tsaoc_pkg::OFF_STATUS, 32'h3);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "cleared");
      $display("test invert done");
   endtask : t_invert

   // Power save needs both pins high; conversion freezes meanwhile
   task automatic t_psave();
      level(256, 3);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      chk({30'h0, code_oe, f_oe}, 32'h0, "released");
      chk({31'h0, save_act}, 32'h0, "request low");
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      chk({31'h0, save_act}, 32'h1, "both high");
      level(600, 0);
      apb(1'b0, tsaoc_pkg::OFF_SAMPLE, 32'h0);
      chk(rd & 32'h13FF, 32'h1100, "frozen sample");
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      chk({30'h0, save_act, code_oe}, 32'h1, "enable low wakes");
      chk({22'h0, cap_code}, 32'd600, "resumed");
      pins(1'b1, 1'b1, 1'b0, 1'b0);
      $display("test power save done");
   endtask : t_psave

   task automatic t_run();
      apb(1'b1, tsaoc_pkg::OFF_CTRL, 32'h0);
      level(700, 0);
      chk({22'h0, cap_code}, 32'd600, "held while stopped");
      apb(1'b1, tsaoc_pkg::OFF_CTRL, tsaoc_pkg::CTRL_RST);
      repeat (4) @(posedge clk);
      chk({22'h0, cap_code}, 32'd700, "running again");
      $display("test run done");
   endtask : t_run

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   // Main sequence; enable and power save pins start low so the reset default is visible
   initial begin
      fail_count  = 0;
      checks_done = 0;
      rstn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      coarse_lvl = 12'sh000;
      fine_lvl   = 12'sh000;
      {msb_inv_n, low_inv_n, oen, save_req} = 4'hC;
      repeat (2) @(posedge clk);
      chk({31'h0, code_oe}, 32'h0, "released in reset");
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_codes();
      t_invert();
      t_psave();
      t_run();
      summarize();
   end

   // Whole run needs well under 2000 cycles; cut a hang at 20000
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
endmodule : testbench

`default_nettype wire

// ---- dv/tsaoc_capture.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Downstream capture of converted samples
// ----------------------------------------
module tsaoc_capture (
   // Clock
   input  wire logic       clk,
   // Sample bus as the converter drives it
   input  wire logic [9:0] sample_code,
   input  wire logic       sample_code_oe,
   input  wire logic       top_exceed_flag,
   input  wire logic       bottom_exceed_flag,
   input  wire logic       flags_oe,
   // Captured word
   output logic      [9:0] cap_code,
   output logic            cap_top,
   output logic            cap_bot
);
   logic [11:0] last_q;
   logic [11:0] wire_lvl;

   // No pull on these lines, so a released bus shows the inverse of the last value
   assign wire_lvl = {flags_oe ? {top_exceed_flag, bottom_exceed_flag} : ~last_q[11:10],
                      sample_code_oe ? sample_code : ~last_q[9:0]};

   // Capture on the rising edge that follows the converter's launch edge
   always_ff @(posedge clk) begin
      last_q <= wire_lvl;
   end

   // Captured fields
   assign cap_code = last_q[9:0];
   assign cap_top  = last_q[11];
   assign cap_bot  = last_q[10];
endmodule : tsaoc_capture

`default_nettype wire
